// >>> ilcs_pkg.sv
// package for the in-band loop code switch of one t1 channel.
// assumes a single 250 mhz clock and bit strobes from the framer.
package ilcs_pkg;

  // ****************************************************************
  // sequence and detection figures
  // ****************************************************************
  localparam int          SEQ_BITS     = 51200; // bits per detection unit
  // miss budget per sequence; an error spoils up to 8 windows
  localparam logic [15:0] MISS_LIMIT   = 16'h1400;
  localparam logic [15:0] SEQ_LAST     = 16'hc7ff; // SEQ_BITS - 1
  localparam logic [7:0]  DET_TIME_00  = 8'h10;    // 16 sequences
  localparam logic [7:0]  DET_TIME_01  = 8'h20;
  localparam logic [7:0]  DET_TIME_10  = 8'h40;
  localparam logic [7:0]  DET_TIME_11  = 8'h80;

  // ****************************************************************
  // standard codes, oldest bit in the top of the used length
  // ****************************************************************
  localparam logic [7:0]  STD_UP_PAT   = 8'h10;    // 10000
  localparam logic [1:0]  STD_UP_LEN   = 2'h0;     // length 5
  localparam logic [7:0]  STD_DN_PAT   = 8'h24;    // 100100
  localparam logic [1:0]  STD_DN_LEN   = 2'h1;     // length 6
  localparam int          PAT_MIN_LEN  = 5;

  // ****************************************************************
  // transmit hold time
  // ****************************************************************
  localparam int          TX_HOLD_S    = 5;
  localparam int          CLK_HZ       = 250000000;
  localparam int          TX_HOLD_CYC  = TX_HOLD_S * CLK_HZ;

  // ****************************************************************
  // status bit positions
  // ****************************************************************
  localparam int          ST_LINE_UP   = 0;
  localparam int          ST_LINE_DN   = 1;
  localparam int          ST_SYS_UP    = 2;
  localparam int          ST_SYS_DN    = 3;
  localparam int          SIDE_LINE    = 0;
  localparam int          SIDE_SYS     = 1;

  // one bit slot of a t1 stream
  typedef struct packed {
    logic valid; // this cycle carries a bit
    logic fbit;  // the bit is the frame bit
    logic data;  // the bit itself
  } ilcs_bit_t;

endpackage : ilcs_pkg

// >>> ilcs_top.sv
// in-band loop code generator, detector and loop switch, one channel.
// assumes bit strobes synchronous to clk and a loop datapath outside
// that acts on the loop close outputs.
//
// Functional notes
// R1 - detect over sequences of 51200 bits
// R2 - tolerate one bit error per hundred
// R3 - framed codes skip frame bit, unframed use it
// R4 - per side reception time; line 00 is 16
// R5 - status set after one detected sequence
// R6 - status set even without auto switching
// R7 - each status bit masked before interrupt output
// R8 - send requested code for at least 5 seconds
// R9 - user patterns replace standard codes when selected
// R10 - up and down lengths 5 to 8 each
// R11 - separate auto enables for system and line
// R12 - line side act and deact detect status
// R13 - auto loop ored with software loop bit
// R14 - jitter select applies to auto remote loop
// R15 - line up closes remote unless local set
// R16 - system codes open and close local loop
// R17 - software never sets both auto enables
// R18 - codes seen before enable never switch
// R19 - clearing enable opens its auto loop
// R20 - line and system sides fully independent
// R21 - pattern matched at any bit phase
`timescale 1ns/1ps
`default_nettype none
module ilcs_top
  import ilcs_pkg::*;
#(
  parameter int TX_HOLD = TX_HOLD_CYC // shorten for simulation
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire ilcs_bit_t  line_rx,               // bits from the line
  input  wire ilcs_bit_t  sys_rx,                // bits from the system
  input  wire ilcs_bit_t  line_tx_slot,          // outgoing line slots
  input  wire ilcs_bit_t  sys_tx_slot,           // outgoing system slots
  input  wire logic [1:0] framed_code_select,    // [side], 1 framed
  input  wire logic       user_pattern_select,
  input  wire logic [7:0] pattern_reg_a,         // user loop-up
  input  wire logic [7:0] pattern_reg_b,         // user loop-down
  input  wire logic [1:0] up_pattern_length,     // 0..3 -> 5..8
  input  wire logic [1:0] down_pattern_length,
  input  wire logic [1:0] system_detect_time,
  input  wire logic [1:0] line_detect_time,
  input  wire logic       system_auto_switch_en,
  input  wire logic       line_auto_switch_en,
  input  wire logic [1:0] send_loop_up,          // [side]
  input  wire logic [1:0] send_loop_down,        // [side]
  input  wire logic       local_loop_bit,
  input  wire logic       remote_loop_bit,
  input  wire logic       jitter_atten_select,
  input  wire logic [3:0] loop_code_irq_mask,    // 1 masks the bit
  input  wire logic [3:0] loop_code_irq_clear,   // pulse per bit
  output logic      [3:0] loop_code_irq_status,
  output logic            loop_code_irq,
  output logic            line_act_detected,
  output logic            line_deact_detected,
  output logic            remote_loop_close,
  output logic            local_loop_close,
  output logic            jitter_atten_select_in_loop,
  output logic            line_tx_data,
  output logic            sys_tx_data
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // true when the newest bits form any rotation of the pattern
  function automatic logic ilcs_match(input logic [7:0] w,
                                      input logic [7:0] pat,
                                      input logic [1:0] lsel);
    int len;
    logic ok;
    logic hit;
    len = PAT_MIN_LEN + int'(lsel);
    hit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      ok = (r < len);
      for (int i = 0; i < 8; i++) begin
        if (i < len && r < len && w[i] != pat[(i + r) % len]) begin
          ok = 1'b0;
        end
      end
      hit = hit | ok;
    end
    return hit;
  endfunction : ilcs_match

  // sequences needed before a switch
  function automatic logic [7:0] ilcs_det_time(input logic [1:0] sel);
    unique case (sel)
      2'h0: return DET_TIME_00; // see R4
      2'h1: return DET_TIME_01;
      2'h2: return DET_TIME_10;
      2'h3: return DET_TIME_11;
    endcase
  endfunction : ilcs_det_time

  // ****************************************************************
  // side mapping and active patterns
  // ****************************************************************
  ilcs_bit_t  rx      [2];        // index by side
  ilcs_bit_t  txs     [2];
  logic [1:0] dtime   [2];
  logic [1:0] en;                 // auto enable per side
  logic [7:0] up_pat, dn_pat;
  logic [1:0] up_len, dn_len;

  assign rx[SIDE_LINE]    = line_rx;
  assign rx[SIDE_SYS]     = sys_rx;
  assign txs[SIDE_LINE]   = line_tx_slot;
  assign txs[SIDE_SYS]    = sys_tx_slot;
  assign dtime[SIDE_LINE] = line_detect_time;
  assign dtime[SIDE_SYS]  = system_detect_time;
  assign en = {system_auto_switch_en, line_auto_switch_en}; // see R11
  // user patterns replace both codes on both sides
  assign up_pat = user_pattern_select ? pattern_reg_a : STD_UP_PAT; // see R9
  assign dn_pat = user_pattern_select ? pattern_reg_b : STD_DN_PAT;
  assign up_len = user_pattern_select ? up_pattern_length : STD_UP_LEN; // see R10
  assign dn_len = user_pattern_select ? down_pattern_length : STD_DN_LEN;

  // ****************************************************************
  // detector state, one copy per side
  // ****************************************************************
  logic [7:0]  hist_r   [2], hist_nxt   [2];  // newest bit in bit 0
  logic [15:0] seq_r    [2], seq_nxt    [2];  // bits in this sequence
  logic [15:0] mup_r    [2], mup_nxt    [2];  // loop-up misses
  logic [15:0] mdn_r    [2], mdn_nxt    [2];  // loop-down misses
  logic [7:0]  pup_r    [2], pup_nxt    [2];  // loop-up run length
  logic [7:0]  pdn_r    [2], pdn_nxt    [2];
  logic        bup_r    [2], bup_nxt    [2];  // up run began unarmed
  logic        bdn_r    [2], bdn_nxt    [2];
  logic        cnt_bit  [2];                  // bit takes part
  logic        seq_end  [2];                  // sequence completes
  logic        hit_up   [2], hit_dn     [2];  // sequence verdicts
  logic        sw_up    [2], sw_dn      [2];  // reception time reached

  // counts misses and judges each sequence
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      hist_nxt[s] = hist_r[s];
      seq_nxt[s]  = seq_r[s];
      mup_nxt[s]  = mup_r[s];
      mdn_nxt[s]  = mdn_r[s];
      pup_nxt[s]  = pup_r[s];
      pdn_nxt[s]  = pdn_r[s];
      bup_nxt[s]  = bup_r[s];
      bdn_nxt[s]  = bdn_r[s];
      // framed codes leave the frame bit out entirely
      cnt_bit[s] = rx[s].valid &
                   ~(framed_code_select[s] & rx[s].fbit); // see R3
      seq_end[s] = cnt_bit[s] && seq_r[s] == SEQ_LAST; // see R1
      hit_up[s]  = 1'b0;
      hit_dn[s]  = 1'b0;
      sw_up[s]   = 1'b0;
      sw_dn[s]   = 1'b0;
      if (cnt_bit[s]) begin
        hist_nxt[s] = {hist_r[s][6:0], rx[s].data};
        // any rotation counts, so frame alignment is irrelevant
        if (!ilcs_match(hist_nxt[s], up_pat, up_len)) begin // see R21
          mup_nxt[s] = mup_r[s] + 16'h1;
        end
        if (!ilcs_match(hist_nxt[s], dn_pat, dn_len)) begin
          mdn_nxt[s] = mdn_r[s] + 16'h1;
        end
        seq_nxt[s] = seq_r[s] + 16'h1;
      end
      if (seq_end[s]) begin
        // a miss budget rather than exact match rides out bit errors
        hit_up[s]  = mup_nxt[s] <= MISS_LIMIT; // see R2
        hit_dn[s]  = mdn_nxt[s] <= MISS_LIMIT;
        seq_nxt[s] = 16'h0;
        mup_nxt[s] = 16'h0;
        mdn_nxt[s] = 16'h0;
        // runs of detected sequences, saturating
        pup_nxt[s] = !hit_up[s] ? 8'h0 :
                     (pup_r[s] == 8'hff) ? pup_r[s] : pup_r[s] + 8'h1;
        pdn_nxt[s] = !hit_dn[s] ? 8'h0 :
                     (pdn_r[s] == 8'hff) ? pdn_r[s] : pdn_r[s] + 8'h1;
        // runs begun while disarmed never switch
        bup_nxt[s] = hit_up[s] & (bup_r[s] | ~en[s]); // see R18
        bdn_nxt[s] = hit_dn[s] & (bdn_r[s] | ~en[s]);
        sw_up[s] = hit_up[s] & ~bup_nxt[s] &
                   pup_nxt[s] == ilcs_det_time(dtime[s]); // see R4
        sw_dn[s] = hit_dn[s] & ~bdn_nxt[s] &
                   pdn_nxt[s] == ilcs_det_time(dtime[s]);
      end else if (!en[s]) begin
        // a code seen while disarmed stays barred
        bup_nxt[s] = bup_r[s] | (pup_r[s] != 8'h0);
        bdn_nxt[s] = bdn_r[s] | (pdn_r[s] != 8'h0);
      end
    end
  end

  // registers the detector, both sides kept apart
  always_ff @(posedge clk or negedge reset_n) begin
    for (int s = 0; s < 2; s++) begin
      if (!reset_n) begin
        hist_r[s] <= 8'h0;
        seq_r[s]  <= 16'h0;
        mup_r[s]  <= 16'h0;
        mdn_r[s]  <= 16'h0;
        pup_r[s]  <= 8'h0;
        pdn_r[s]  <= 8'h0;
        bup_r[s]  <= 1'b0;
        bdn_r[s]  <= 1'b0;
      end else begin // see R20
        hist_r[s] <= hist_nxt[s];
        seq_r[s]  <= seq_nxt[s];
        mup_r[s]  <= mup_nxt[s];
        mdn_r[s]  <= mdn_nxt[s];
        pup_r[s]  <= pup_nxt[s];
        pdn_r[s]  <= pdn_nxt[s];
        bup_r[s]  <= bup_nxt[s];
        bdn_r[s]  <= bdn_nxt[s];
      end
    end
  end

  // ****************************************************************
  // status, interrupt and loop switching
  // ****************************************************************
  logic [3:0] st_r, st_nxt;     // sticky code status
  logic       irq_r, irq_nxt;
  logic       act_r, act_nxt, dact_r, dact_nxt;
  logic       arem_r, arem_nxt; // auto remote loop
  logic       aloc_r, aloc_nxt; // auto local loop
  logic       rem_r, rem_nxt, loc_r, loc_nxt, jat_r, jat_nxt;
  logic [3:0] st_set;

  // status per sequence, switching per run
  always_comb begin
    st_set = {hit_dn[SIDE_SYS], hit_up[SIDE_SYS],
              hit_dn[SIDE_LINE], hit_up[SIDE_LINE]}; // see R5
    // set beats a same-cycle clear; enable plays no part
    st_nxt = (st_r & ~loop_code_irq_clear) | st_set; // see R6
    irq_nxt = |(st_nxt & ~loop_code_irq_mask); // see R7
    act_nxt  = act_r;
    dact_nxt = dact_r;
    if (seq_end[SIDE_LINE]) begin
      act_nxt  = hit_up[SIDE_LINE]; // see R12
      dact_nxt = hit_dn[SIDE_LINE];
    end
    arem_nxt = arem_r;
    // software local loop bit blocks remote activation to avoid lock up
    if (sw_up[SIDE_LINE] && !local_loop_bit) begin // see R15
      arem_nxt = 1'b1;
    end
    if (sw_dn[SIDE_LINE] || !line_auto_switch_en) begin // see R19
      arem_nxt = 1'b0;
    end
    aloc_nxt = aloc_r;
    if (sw_up[SIDE_SYS]) begin // see R16
      aloc_nxt = 1'b1;
    end
    if (sw_dn[SIDE_SYS] || !system_auto_switch_en) begin // see R19
      aloc_nxt = 1'b0;
    end
    rem_nxt = arem_nxt | remote_loop_bit; // see R13
    loc_nxt = aloc_nxt | local_loop_bit;
    jat_nxt = rem_nxt & jitter_atten_select; // see R14
  end

  // registers status and loop controls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r   <= 4'h0;
      irq_r  <= 1'b0;
      act_r  <= 1'b0;
      dact_r <= 1'b0;
      arem_r <= 1'b0;
      aloc_r <= 1'b0;
      rem_r  <= 1'b0;
      loc_r  <= 1'b0;
      jat_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      irq_r  <= irq_nxt;
      act_r  <= act_nxt;
      dact_r <= dact_nxt;
      arem_r <= arem_nxt;
      aloc_r <= aloc_nxt;
      rem_r  <= rem_nxt;
      loc_r  <= loc_nxt;
      jat_r  <= jat_nxt;
    end
  end

  // ****************************************************************
  // generator, one copy per side
  // ****************************************************************
  logic [31:0] tmr_r [2], tmr_nxt [2];  // hold time left
  logic        dn_r  [2], dn_nxt  [2];  // sending loop-down
  logic [2:0]  ph_r  [2], ph_nxt  [2];  // pattern bit index
  logic        tx_r  [2], tx_nxt  [2];
  logic [7:0]  gpat  [2];
  logic [2:0]  glast [2];

  // a request restarts the hold timer
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      tmr_nxt[s] = tmr_r[s];
      dn_nxt[s]  = dn_r[s];
      ph_nxt[s]  = ph_r[s];
      tx_nxt[s]  = tx_r[s];
      if (send_loop_up[s] || send_loop_down[s]) begin
        tmr_nxt[s] = 32'(TX_HOLD); // see R8
        dn_nxt[s]  = ~send_loop_up[s]; // up has priority
      end else if (tmr_r[s] != 32'h0) begin
        tmr_nxt[s] = tmr_r[s] - 32'h1;
      end
      gpat[s]  = dn_r[s] ? dn_pat : up_pat;
      glast[s] = 3'(PAT_MIN_LEN - 1) + {1'b0, dn_r[s] ? dn_len : up_len};
      if (txs[s].valid) begin
        tx_nxt[s] = txs[s].data;
        // framed codes keep the framer's frame bit
        if (tmr_r[s] != 32'h0 &&
            !(framed_code_select[s] && txs[s].fbit)) begin // see R3
          tx_nxt[s] = gpat[s][glast[s] - ph_r[s]];
          ph_nxt[s] = (ph_r[s] >= glast[s]) ? 3'h0 : ph_r[s] + 3'h1;
        end
      end
    end
  end

  // registers the generator
  always_ff @(posedge clk or negedge reset_n) begin
    for (int s = 0; s < 2; s++) begin
      if (!reset_n) begin
        tmr_r[s] <= 32'h0;
        dn_r[s]  <= 1'b0;
        ph_r[s]  <= 3'h0;
        tx_r[s]  <= 1'b0;
      end else begin
        tmr_r[s] <= tmr_nxt[s];
        dn_r[s]  <= dn_nxt[s];
        ph_r[s]  <= ph_nxt[s];
        tx_r[s]  <= tx_nxt[s];
      end
    end
  end

  // ****************************************************************
  // outputs, all straight from flip-flops
  // ****************************************************************
  assign loop_code_irq_status = st_r;
  assign loop_code_irq        = irq_r;
  assign line_act_detected    = act_r;
  assign line_deact_detected  = dact_r;
  assign remote_loop_close    = rem_r;
  assign local_loop_close     = loc_r;
  assign jitter_atten_select_in_loop         = jat_r;
  assign line_tx_data         = tx_r[SIDE_LINE];
  assign sys_tx_data          = tx_r[SIDE_SYS];

endmodule : ilcs_top
`default_nettype wire

// >>> ilcs_chk_sva.sv
// checker of the loop code switch, watching the top ports only.
// assumes one clock domain and the active low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ilcs_chk
  import ilcs_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire ilcs_bit_t  line_rx,               // bits from the line
  input wire logic       line_auto_switch_en,
  input wire logic       system_auto_switch_en,
  input wire logic       local_loop_bit,
  input wire logic       remote_loop_bit,
  input wire logic       jitter_atten_select,
  input wire logic [3:0] loop_code_irq_mask,
  input wire logic [3:0] loop_code_irq_clear,
  input wire logic [3:0] loop_code_irq_status,
  input wire logic       loop_code_irq,
  input wire logic       remote_loop_close,
  input wire logic       local_loop_close,
  input wire logic       jitter_atten_select_in_loop
);
  // ****************************************************************
  // clocking
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // status and interrupt
  // ****************************************************************
  // status falls only by its clear
  status_hold_a: assert property (loop_code_irq_status[0] &&
    !loop_code_irq_clear[0] |=> loop_code_irq_status[0])
    else $error("line up status dropped without clear");
  // a set needs a received bit at that edge
  status_cause_a: assert property ($rose(loop_code_irq_status[0])
    |-> $past(line_rx.valid)) else $error("status set without a bit");
  irq_follow_a: assert property ($rose(loop_code_irq_status[0]) &&
    !loop_code_irq_mask[0] |=> loop_code_irq)
    else $error("unmasked status gave no interrupt");
  irq_masked_a: assert property (loop_code_irq_mask == 4'hf
    |=> !loop_code_irq) else $error("interrupt while all masked");

  // ****************************************************************
  // loop outputs
  // ****************************************************************
  remote_or_a: assert property ($past(reset_n) &&
    $past(remote_loop_bit) |-> remote_loop_close)
    else $error("software remote loop not closed");
  local_or_a: assert property ($past(reset_n) &&
    $past(local_loop_bit) |-> local_loop_close)
    else $error("software local loop not closed");
  jitter_atten_select_gate_a: assert property (jitter_atten_select_in_loop |->
    $past(jitter_atten_select) && (remote_loop_close ||
    $past(remote_loop_close))) else $error("jitter path without cause");
  // a low enable leaves only the software loop
  line_drop_a: assert property (!$past(line_auto_switch_en) &&
    !$past(line_auto_switch_en, 2) && !$past(remote_loop_bit)
    |-> !remote_loop_close) else $error("remote loop kept closed");
  sys_drop_a: assert property (!$past(system_auto_switch_en) &&
    !$past(system_auto_switch_en, 2) && !$past(local_loop_bit)
    |-> !local_loop_close) else $error("local loop kept closed");
endmodule : ilcs_chk

bind ilcs_top ilcs_chk i_ilcs_chk (.clk, .reset_n, .line_rx,
  .line_auto_switch_en, .system_auto_switch_en, .local_loop_bit,
  .remote_loop_bit, .jitter_atten_select, .loop_code_irq_mask,
  .loop_code_irq_clear, .loop_code_irq_status, .loop_code_irq,
  .remote_loop_close, .local_loop_close, .jitter_atten_select_in_loop);
`default_nettype wire

// >>> ilcs_stream_src.sv
// far side model: a t1 stream repeating one loop code.
// assumes one bit per clock while enabled, 193 bit frames.
`timescale 1ns/1ps
`default_nettype none
module ilcs_stream_src
  import ilcs_pkg::*;
#(
  parameter int START = 0 // first pattern bit sent
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       en,        // send the code
  input  wire logic [7:0] pat,       // used bits len+4..0
  input  wire logic [1:0] len,       // 0..3 for 5..8 bits
  input  wire logic       framed,    // frame bit carries no code
  input  wire logic [7:0] err_every, // one flipped bit per this many, per 256 when 0
  output var  ilcs_bit_t  bit_o
);
  logic [2:0] idx_r;  // next pattern bit to send
  logic [7:0] fcnt_r; // slot within the frame
  logic [7:0] ecnt_r; // code bits since the last error
  // ****************************************************************
  // bit source
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_r  <= 3'(START);
      fcnt_r <= 8'h00;
      ecnt_r <= 8'h00;
      bit_o  <= '0;
    end else if (!en) begin
      bit_o.valid <= 1'h0;
      bit_o.data  <= ~bit_o.data; // idle line shows no stale value
    end else begin
      bit_o.valid <= 1'h1;
      bit_o.fbit  <= (fcnt_r == 8'h00);
      fcnt_r      <= (fcnt_r == 8'hc0) ? 8'h00 : fcnt_r + 8'h01;
      if (fcnt_r == 8'h00 && framed) begin
        bit_o.data <= ~pat[idx_r]; // noise in the frame bit
      end else begin
        // flipped bits test the miss budget
        bit_o.data <= pat[idx_r] ^ (ecnt_r == err_every - 8'h01);
        ecnt_r     <= (ecnt_r == err_every - 8'h01) ? 8'h00 : ecnt_r + 8'h01;
        idx_r      <= (idx_r == 3'h0) ? 3'(len) + 3'h4 : idx_r - 3'h1;
      end
    end
  end
endmodule : ilcs_stream_src
`default_nettype wire

// >>> tb_top.sv
// testbench of the loop code switch: loops, sending, detection.
// assumes the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ilcs_pkg::*;
  localparam int HOLD = 50;         // short code hold
  logic       clk                   = 1'h0;
  logic       reset_n               = 1'h0;
  ilcs_bit_t  line_rx;              // from the line model
  ilcs_bit_t  sys_rx;               // from the system model
  ilcs_bit_t  line_tx_slot          = '0;
  ilcs_bit_t  sys_tx_slot           = '0;
  logic [1:0] framed_code_select    = 2'h0;
  logic       user_pattern_select   = 1'h0;
  logic [7:0] pattern_reg_a         = 8'h0e; // 7 bit loop-up
  logic [7:0] pattern_reg_b         = 8'hd2; // 8 bit loop-down
  logic [1:0] up_pattern_length     = 2'h2;
  logic [1:0] down_pattern_length   = 2'h3;
  logic [1:0] system_detect_time    = 2'h0;  // switching is out of reach
  logic [1:0] line_detect_time      = 2'h0;
  logic       system_auto_switch_en = 1'h0;
  logic       line_auto_switch_en   = 1'h0;
  logic [1:0] send_loop_up          = 2'h0;
  logic [1:0] send_loop_down        = 2'h0;
  logic       local_loop_bit        = 1'h0;
  logic       remote_loop_bit       = 1'h0;
  logic       jitter_atten_select   = 1'h0;
  logic [3:0] loop_code_irq_mask    = 4'he;
  logic [3:0] loop_code_irq_clear   = 4'h0;
  logic [3:0] loop_code_irq_status;
  logic       loop_code_irq, line_act_detected, line_deact_detected;
  logic       remote_loop_close, local_loop_close, jitter_atten_select_in_loop;
  logic       line_tx_data, sys_tx_data;
  logic       line_en               = 1'h0;
  logic       sys_en                = 1'h0;
  int         error_cnt             = 0;
  int         check_count           = 0;

  always #2 clk = ~clk;

  ilcs_top #(.TX_HOLD(HOLD)) i_ilcs_top (.clk, .reset_n, .line_rx,
    .sys_rx, .line_tx_slot, .sys_tx_slot, .framed_code_select,
    .user_pattern_select, .pattern_reg_a, .pattern_reg_b,
    .up_pattern_length, .down_pattern_length, .system_detect_time,
    .line_detect_time, .system_auto_switch_en, .line_auto_switch_en,
    .send_loop_up, .send_loop_down, .local_loop_bit, .remote_loop_bit,
    .jitter_atten_select, .loop_code_irq_mask, .loop_code_irq_clear,
    .loop_code_irq_status, .loop_code_irq, .line_act_detected,
    .line_deact_detected, .remote_loop_close, .local_loop_close,
    .jitter_atten_select_in_loop, .line_tx_data, .sys_tx_data);
  // line: loop-up, 1 error per 100 bits
  ilcs_stream_src #(.START(3)) i_ilcs_stream_src (.clk, .reset_n,
    .en(line_en), .pat(pattern_reg_a), .len(up_pattern_length),
    .framed(framed_code_select[0]), .err_every(8'h64), .bit_o(line_rx));
  ilcs_stream_src #(.START(6)) i_ilcs_stream_src_sys (.clk, .reset_n,
    .en(sys_en), .pat(pattern_reg_b), .len(down_pattern_length),
    .framed(framed_code_select[1]), .err_every(8'h00), .bit_o(sys_rx));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1; // inputs move just after the edge
  endtask : step

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("mismatches %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // software loops, and an enable with no code
  task automatic t_soft;
    chk("status after reset", 8'h00, {4'h0, loop_code_irq_status});
    remote_loop_bit     = 1'h1;
    jitter_atten_select = 1'h1;
    step(2);
    chk("remote close", 8'h01, {7'h0, remote_loop_close});
    chk("jitter in loop", 8'h01, {7'h0, jitter_atten_select_in_loop});
    remote_loop_bit = 1'h0;
    local_loop_bit  = 1'h1;
    step(2);
    chk("local close", 8'h01, {7'h0, local_loop_close});
    chk("remote open", 8'h00, {7'h0, remote_loop_close});
    local_loop_bit      = 1'h0;
    line_auto_switch_en = 1'h1; // one enable at a time
    step(4);
    chk("no code no loop", 8'h00, {7'h0, remote_loop_close});
    line_auto_switch_en = 1'h0;
  endtask : t_soft

  // line sends loop-up framed, system sends loop-down unframed
  task automatic t_tx;
    logic lb[$];
    logic sb[$];
    int   miss;
    int   ones;
    framed_code_select = 2'h1;
    send_loop_up       = 2'h1;
    send_loop_down     = 2'h2;
    step();
    send_loop_up   = 2'h0;
    send_loop_down = 2'h0;
    // a slot every other cycle, read once settled
    for (int i = 0; i < 20; i++) begin
      line_tx_slot = '{1'h1, i == 9, 1'h1};
      sys_tx_slot  = '{1'h1, 1'h0, 1'h1};
      step();
      line_tx_slot.valid = 1'h0;
      sys_tx_slot.valid  = 1'h0;
      step();
      if (i == 9) chk("frame slot", 8'h01, {7'h0, line_tx_data});
      else lb.push_back(line_tx_data);
      sb.push_back(sys_tx_data);
    end
    miss = 0;
    for (int j = 0; j < 14; j++) miss += (lb[j] !== lb[j+5]);
    for (int j = 0; j < 14; j++) miss += (sb[j] !== sb[j+6]);
    chk("code period misses", 8'h00, 8'(miss));
    ones = 0;
    for (int j = 0; j < 5; j++) ones += lb[j];
    chk("loop-up ones", 8'h01, 8'(ones));
    ones = 0;
    for (int j = 0; j < 6; j++) ones += sb[j];
    chk("loop-down ones", 8'h02, 8'(ones));
    step(30);
    // hold over: payload passes
    for (int v = 0; v < 2; v++) begin
      line_tx_slot = '{1'h1, 1'h0, v[0]};
      sys_tx_slot  = '{1'h1, 1'h0, v[0]};
      step();
      line_tx_slot.valid = 1'h0;
      sys_tx_slot.valid  = 1'h0;
      step();
      chk("line payload", {7'h0, v[0]}, {7'h0, line_tx_data});
      chk("sys payload", {7'h0, v[0]}, {7'h0, sys_tx_data});
    end
  endtask : t_tx

  // user codes received on both sides
  task automatic t_detect;
    int n;
    user_pattern_select = 1'h1;
    framed_code_select  = 2'h2;
    line_en             = 1'h1;
    sys_en              = 1'h1;
    for (n = 0; n < 60000; n++) begin
      if (loop_code_irq_status[0] === 1'h1 &&
          loop_code_irq_status[3] === 1'h1) break;
      step();
    end
    if (n == 60000) begin
      error_cnt++;
      stop_test();
    end
    chk("status", 8'h09, {4'h0, loop_code_irq_status});
    chk("line act", 8'h01, {7'h0, line_act_detected});
    chk("line deact", 8'h00, {7'h0, line_deact_detected});
    step();
    chk("irq", 8'h01, {7'h0, loop_code_irq});
    chk("no auto loop", 8'h00, {7'h0, remote_loop_close});
    loop_code_irq_mask = 4'hf;
    step(2);
    chk("irq masked", 8'h00, {7'h0, loop_code_irq});
    loop_code_irq_clear = 4'h9;
    step();
    loop_code_irq_clear = 4'h0;
    step();
    chk("status cleared", 8'h00, {4'h0, loop_code_irq_status});
  endtask : t_detect

  initial begin
    step(8);
    reset_n = 1'h1;
    step();
    t_soft();
    t_tx();
    t_detect();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
